/* spfm_mux.sv */
// What this block does
// - After reset muxed pins carry default functions
// - Enable bit hands pin to GPIO, direction
// - GPIO 9-15 only without PCI, when enabled
// - ATM strap low: serial port one pins
// - ATM strap high: pins become ATM addresses
// - PCI strap low: pins carry host port
// - PCI strap high: host pins become PCI
// - Deselected standalone peripheral pins stay high-impedance
// - Straps latched once; software mux anytime
// - Width strap: narrow mode floats upper data unless PCI selected
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`include "spfm_params.svh"
module spfm_mux
  import spfm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic pci_select_strap,
  input wire logic atm_port_select_strap,
  input wire logic host_width_strap_pin,
  input wire logic quarter_rate_clock_src,
  input wire logic sixth_rate_clock_src,
  output logic serial2_external_clock_in,
  input wire logic [`SPFM_GP_W-1:0] gp_pad_i,
  output logic [`SPFM_GP_W-1:0] gp_pad_o,
  output logic [`SPFM_GP_W-1:0] gp_pad_oe,
  input wire logic [`SPFM_PGP_W-1:0] pci_gp_o,
  input wire logic [`SPFM_PGP_W-1:0] pci_gp_oe,
  output logic [`SPFM_PGP_W-1:0] pci_gp_i,
  input wire logic [`SPFM_S1_W-1:0] s1_pad_i,
  output logic [`SPFM_S1_W-1:0] s1_pad_o,
  output logic [`SPFM_S1_W-1:0] s1_pad_oe,
  input wire logic [`SPFM_S1_W-1:0] sp1_o,
  input wire logic [`SPFM_S1_W-1:0] sp1_oe,
  output logic [`SPFM_S1_W-1:0] sp1_i,
  input wire logic [`SPFM_S1_W-1:0] atm_sh_o,
  input wire logic [`SPFM_S1_W-1:0] atm_sh_oe,
  output logic [`SPFM_S1_W-1:0] atm_sh_i,
  input wire logic [`SPFM_S2_W-1:0] s2_pad_i,
  output logic [`SPFM_S2_W-1:0] s2_pad_o,
  output logic [`SPFM_S2_W-1:0] s2_pad_oe,
  input wire logic [`SPFM_S2_W-1:0] sp2_o,
  input wire logic [`SPFM_S2_W-1:0] sp2_oe,
  output logic [`SPFM_S2_W-1:0] sp2_i,
  input wire logic [`SPFM_S2_W-1:0] ee_o,
  input wire logic [`SPFM_S2_W-1:0] ee_oe,
  output logic [`SPFM_S2_W-1:0] ee_i,
  input wire logic [`SPFM_HP_W-1:0] hp_pad_i,
  output logic [`SPFM_HP_W-1:0] hp_pad_o,
  output logic [`SPFM_HP_W-1:0] hp_pad_oe,
  input wire logic [`SPFM_HP_W-1:0] host_o,
  input wire logic [`SPFM_HP_W-1:0] host_oe,
  output logic [`SPFM_HP_W-1:0] host_i,
  input wire logic [`SPFM_HP_W-1:0] pci_hp_o,
  input wire logic [`SPFM_HP_W-1:0] pci_hp_oe,
  output logic [`SPFM_HP_W-1:0] pci_hp_i,
  input wire logic [`SPFM_ATM_W-1:0] atm_pad_i,
  output logic [`SPFM_ATM_W-1:0] atm_pad_o,
  output logic [`SPFM_ATM_W-1:0] atm_pad_oe,
  input wire logic [`SPFM_ATM_W-1:0] atm_pin_o,
  input wire logic [`SPFM_ATM_W-1:0] atm_pin_oe,
  output logic [`SPFM_ATM_W-1:0] atm_pin_i,
  input wire logic [`SPFM_PCI_W-1:0] pci_pad_i,
  output logic [`SPFM_PCI_W-1:0] pci_pad_o,
  output logic [`SPFM_PCI_W-1:0] pci_pad_oe,
  input wire logic [`SPFM_PCI_W-1:0] pci_pin_o,
  input wire logic [`SPFM_PCI_W-1:0] pci_pin_oe,
  output logic [`SPFM_PCI_W-1:0] pci_pin_i,
  output logic [`SPFM_STRAP_W:0] strap_status
);
  import spfm_pkg::*;

  spfm_state_t s;
  spfm_state_t next_s;
  logic accept;
  logic [`SPFM_GP_W-1:0] sy_gp;
  logic [`SPFM_S1_W-1:0] sy_s1;
  logic [`SPFM_S2_W-1:0] sy_s2;
  logic [`SPFM_HP_W-1:0] sy_hp;
  logic [`SPFM_ATM_W-1:0] sy_atm;
  logic [`SPFM_PCI_W-1:0] sy_pci;
  logic [`SPFM_STRAP_W-1:0] sy_strap;

  spfm_sync_if #(.W(`SPFM_SYNC_W)) pads ();

  // Every pad and strap crosses in from outside the clock domain
  assign pads.raw = {host_width_strap_pin, atm_port_select_strap, pci_select_strap,
                     pci_pad_i, atm_pad_i, hp_pad_i, s2_pad_i, s1_pad_i, gp_pad_i};
  assign {sy_strap, sy_pci, sy_atm, sy_hp, sy_s2, sy_s1, sy_gp} = pads.sync;

  spfm_sync #(.W(`SPFM_SYNC_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .port(pads.snk)
  );

  // Zero wait state slave; hsize is ignored, every access is a whole word
  assign accept = hsel & htrans[1] & hready;

  always_comb
  begin
    next_s = s;
    // Data phase write; read data below sees it, so read-after-write is fresh
    if (s.ph_we)
    begin
      case (s.ph_addr)
        `SPFM_OFF_EN: next_s.gpio_en = hwdata[`SPFM_GP_W-1:0];
        `SPFM_OFF_DIR: next_s.gpio_dir = hwdata[`SPFM_GP_W-1:0];
        `SPFM_OFF_OUT: next_s.gpio_out = hwdata[`SPFM_GP_W-1:0];
        default: next_s.gpio_en = next_s.gpio_en;
      endcase
    end
    next_s.ph_we = accept & hwrite;
    next_s.ph_addr = haddr[7:0];
    next_s.gpio_in = sy_gp;
    if (accept && !hwrite)
    begin
      case (haddr[7:0])
        `SPFM_OFF_EN: next_s.hrdata = {16'h0000, next_s.gpio_en};
        `SPFM_OFF_DIR: next_s.hrdata = {16'h0000, next_s.gpio_dir};
        `SPFM_OFF_OUT: next_s.hrdata = {16'h0000, next_s.gpio_out};
        `SPFM_OFF_IN: next_s.hrdata = {16'h0000, s.gpio_in};
        `SPFM_OFF_STRAP: next_s.hrdata = {28'h0000000, s.cap == SPFM_CAP_DONE,
                                          s.host_wide, s.atm_sel, s.pci_sel};
        default: next_s.hrdata = 32'h00000000;
      endcase
    end
    next_s.hreadyout = 1'b1;
    next_s.hresp = 1'b0;

    // Straps taken once the synchroniser holds post-reset levels, then frozen
    unique case (s.cap)
      SPFM_CAP_WAIT:
      begin
        if (s.cap_cnt == `SPFM_STRAP_WAIT)
        begin
          next_s.pci_sel = sy_strap[`SPFM_ST_PCI];
          next_s.atm_sel = sy_strap[`SPFM_ST_ATM];
          next_s.host_wide = sy_strap[`SPFM_ST_WIDE];
          next_s.cap = SPFM_CAP_DONE;
        end
        else
        begin
          next_s.cap_cnt = s.cap_cnt + 2'h1;
        end
      end
      SPFM_CAP_DONE: next_s.cap = SPFM_CAP_DONE;
    endcase

    // General purpose bank
    for (int i = 0; i < `SPFM_GP_W; i++)
    begin
      next_s.gp_o[i] = 1'b0;
      next_s.gp_oe[i] = 1'b0;
      if (i == `SPFM_GP_QCLK)
      begin
        next_s.gp_o[i] = quarter_rate_clock_src;
        next_s.gp_oe[i] = 1'b1;
      end
      else if (i == `SPFM_GP_SCLK)
      begin
        next_s.gp_o[i] = sixth_rate_clock_src;
        next_s.gp_oe[i] = 1'b1;
      end
      else if (i >= `SPFM_GP_PCI_LO && s.pci_sel)
      begin
        next_s.gp_o[i] = pci_gp_o[i-`SPFM_GP_PCI_LO];
        next_s.gp_oe[i] = pci_gp_oe[i-`SPFM_GP_PCI_LO];
      end
      if (s.gpio_en[i] && !(i >= `SPFM_GP_PCI_LO && s.pci_sel))
      begin
        next_s.gp_o[i] = s.gpio_out[i];
        next_s.gp_oe[i] = s.gpio_dir[i];
      end
    end
    // Clock input to serial port two only while its pin is not GPIO
    next_s.s2_clk = s.gpio_en[`SPFM_GP_S2CLK] ? 1'b0 : sy_gp[`SPFM_GP_S2CLK];
    next_s.pci_gp_i = s.pci_sel ? sy_gp[`SPFM_GP_PCI_HI:`SPFM_GP_PCI_LO] : '0;

    // Serial port one or ATM address pins
    next_s.s1_o = s.atm_sel ? atm_sh_o : sp1_o;
    next_s.s1_oe = s.atm_sel ? atm_sh_oe : sp1_oe;
    next_s.sp1_i = s.atm_sel ? '0 : sy_s1;
    next_s.atm_sh_i = s.atm_sel ? sy_s1 : '0;

    // Serial port two or EEPROM
    next_s.s2_o = s.pci_sel ? ee_o : sp2_o;
    next_s.s2_oe = s.pci_sel ? ee_oe : sp2_oe;
    next_s.sp2_i = s.pci_sel ? '0 : sy_s2;
    next_s.ee_i = s.pci_sel ? sy_s2 : '0;

    // Host port or PCI
    next_s.hp_o = s.pci_sel ? pci_hp_o : host_o;
    next_s.hp_oe = s.pci_sel ? pci_hp_oe : host_oe;
    next_s.host_i = s.pci_sel ? '0 : sy_hp;
    next_s.pci_hp_i = s.pci_sel ? sy_hp : '0;
    if (!s.pci_sel && !s.host_wide)
    begin
      // Narrow host mode: upper data lines float and read as zero
      next_s.hp_oe[`SPFM_HD_W-1:`SPFM_HD_NARROW] = '0;
      next_s.host_i[`SPFM_HD_W-1:`SPFM_HD_NARROW] = '0;
    end

    // Standalone pins of deselected peripherals
    next_s.atm_o = s.atm_sel ? atm_pin_o : '0;
    next_s.atm_oe = s.atm_sel ? atm_pin_oe : '0;
    next_s.atm_i = s.atm_sel ? sy_atm : '0;
    next_s.pci_o = s.pci_sel ? pci_pin_o : '0;
    next_s.pci_oe = s.pci_sel ? pci_pin_oe : '0;
    next_s.pci_i = s.pci_sel ? sy_pci : '0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.gpio_en <= `SPFM_EN_RST;
      s.gpio_dir <= `SPFM_DIR_RST;
      s.gpio_out <= `SPFM_OUT_RST;
      s.cap <= SPFM_CAP_WAIT;
      s.hreadyout <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;
  assign serial2_external_clock_in = s.s2_clk;
  assign gp_pad_o = s.gp_o;
  assign gp_pad_oe = s.gp_oe;
  assign pci_gp_i = s.pci_gp_i;
  assign s1_pad_o = s.s1_o;
  assign s1_pad_oe = s.s1_oe;
  assign sp1_i = s.sp1_i;
  assign atm_sh_i = s.atm_sh_i;
  assign s2_pad_o = s.s2_o;
  assign s2_pad_oe = s.s2_oe;
  assign sp2_i = s.sp2_i;
  assign ee_i = s.ee_i;
  assign hp_pad_o = s.hp_o;
  assign hp_pad_oe = s.hp_oe;
  assign host_i = s.host_i;
  assign pci_hp_i = s.pci_hp_i;
  assign atm_pad_o = s.atm_o;
  assign atm_pad_oe = s.atm_oe;
  assign atm_pin_i = s.atm_i;
  assign pci_pad_o = s.pci_o;
  assign pci_pad_oe = s.pci_oe;
  assign pci_pin_i = s.pci_i;
  assign strap_status = {s.cap == SPFM_CAP_DONE, s.host_wide, s.atm_sel, s.pci_sel};
endmodule

/* spfm_mux_assertions.sv */
module spfm_mux_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] strap_status,
  input wire logic [41:0] hp_pad_oe,
  input wire logic [41:0] pci_hp_oe,
  input wire logic [6:0] s1_pad_oe,
  input wire logic [6:0] sp1_oe,
  input wire logic [6:0] atm_sh_oe,
  input wire logic [2:0] s2_pad_oe,
  input wire logic [2:0] ee_oe,
  input wire logic [15:0] gp_pad_oe,
  input wire logic [6:0] pci_gp_oe,
  input wire logic [7:0] atm_pad_oe,
  input wire logic [7:0] pci_pad_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire on = strap_status[3];
  wire pci = on & strap_status[0];
  wire atm = on & strap_status[1];
  strap_hold_a: assert property (on |=> $stable(strap_status))
    else $error("strap selection changed after latch");
  pci_pads_a: assert property (pci |=> hp_pad_oe == $past(pci_hp_oe))
    else $error("host pads not under pci control");
  narrow_host_a: assert property (on && !strap_status[2] && !strap_status[0]
    |=> hp_pad_oe[31:16] == 16'h0000)
    else $error("upper host data driven in narrow mode");
  atm_addr_a: assert property (atm |=> s1_pad_oe == $past(atm_sh_oe))
    else $error("shared pads not under atm control");
  serial_one_a: assert property (on && !atm |=> s1_pad_oe == $past(sp1_oe))
    else $error("shared pads not under serial one control");
  eeprom_pins_a: assert property (pci |=> s2_pad_oe == $past(ee_oe))
    else $error("serial two pads not under eeprom control");
  pci_gpio_a: assert property (pci |=> gp_pad_oe[15:9] == $past(pci_gp_oe))
    else $error("upper gpio pads not under pci control");
  tie_off_a: assert property (on |=> (atm || atm_pad_oe == 8'h00)
    && (pci || pci_pad_oe == 8'h00))
    else $error("deselected standalone pads driven");
endmodule
bind spfm_mux spfm_mux_assertions u_chk (.*);

/* spfm_mux_bench.sv */
module spfm_mux_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, flip = 0, hreadyout, hresp;
  logic quarter_rate_clock_src, sixth_rate_clock_src, serial2_external_clock_in;
  logic pci_select_strap, atm_port_select_strap, host_width_strap_pin;
  wire hready = hreadyout;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, cfg = 0;
  logic [3:0] strap_status;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'hE65BC739;
  logic [95:0] ext;
  logic [15:0] rg [3], gp_pad_i, gp_pad_o, gp_pad_oe, ego, egoe;
  logic [6:0] pci_gp_o, pci_gp_oe, pci_gp_i, s1_pad_i, s1_pad_o, s1_pad_oe;
  logic [6:0] sp1_o, sp1_oe, sp1_i, atm_sh_o, atm_sh_oe, atm_sh_i;
  logic [2:0] s2_pad_i, s2_pad_o, s2_pad_oe, sp2_o, sp2_oe, sp2_i, ee_o, ee_oe, ee_i;
  logic [41:0] hp_pad_i, hp_pad_o, hp_pad_oe, host_o, host_oe, host_i;
  logic [41:0] pci_hp_o, pci_hp_oe, pci_hp_i, eho, ehoe;
  logic [7:0] atm_pad_i, atm_pad_o, atm_pad_oe, atm_pin_o, atm_pin_oe, atm_pin_i;
  logic [7:0] pci_pad_i, pci_pad_o, pci_pad_oe, pci_pin_o, pci_pin_oe, pci_pin_i;
  logic [25:0] eoe;
  // Pad input history: inputs reach peripherals two edges after sampling
  logic [83:0] pd [2], q;
  logic [63:0] ein1, ein2;
  logic [56:0] eout;
  logic [15:0] eap;
  int failures = 0, tests_run = 0, cnt = 0;
  bit vld = 0;
  assign {hp_pad_i, atm_pad_i, pci_pad_i, s1_pad_i, s2_pad_i} = ext[67:0];
  spfm_mux uut (.*);
  spfm_pad_model far (.*);
  initial forever #20 hclk = ~hclk;
  function automatic logic [31:0] nx();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
    return seed;
  endfunction
  task automatic ck(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reads compare against d; writes below 8'h0C also update the bench copy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h000000, a, 2'h2, w};
    do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 50);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 50);
    if (w && a < 8'h0C)
      rg[a[3:2]] <= d[15:0];
    if (!w)
      ck(hrdata, d);
    if (n > 49)
    begin
      failures++;
      tally_and_finish();
    end
  endtask
  always
  begin
    {host_o, host_oe, pci_hp_o, pci_hp_oe, sp1_o, sp1_oe, atm_sh_o, atm_sh_oe, sp2_o, sp2_oe,
      ee_o, ee_oe, atm_pin_o, atm_pin_oe, pci_pin_o, pci_pin_oe, pci_gp_o, pci_gp_oe,
      quarter_rate_clock_src, sixth_rate_clock_src} <=
      {nx(), nx(), nx(), nx(), nx(), nx(), nx(), nx()};
    ext <= {nx(), nx(), nx()};
    @(posedge hclk);
  end
  // Expected pads one edge after their sources, using latched straps
  always @(posedge hclk)
  begin
    cnt = hresetn ? cnt + 1 : 0;
    vld <= cnt > 3;
    ehoe = cfg[0] ? pci_hp_oe : host_oe;
    eho = cfg[0] ? pci_hp_o : host_o;
    if (!cfg[2] && !cfg[0])
      ehoe[31:16] = 16'h0000;
    eoe = {cfg[1] ? atm_sh_oe : sp1_oe, cfg[0] ? ee_oe : sp2_oe, atm_pin_oe & {8{cfg[1]}},
      pci_pin_oe & {8{cfg[0]}}};
    for (int i = 0; i < 16; i++)
    begin
      egoe[i] = cfg[0] && i > 8 ? pci_gp_oe[i - 9] : rg[0][i] ? rg[1][i] : i == 1 || i == 2;
      ego[i] = cfg[0] && i > 8 ? pci_gp_o[i - 9] : rg[0][i] ? rg[2][i] :
        i == 1 ? quarter_rate_clock_src : sixth_rate_clock_src;
    end
    q = pd[1];
    pd[1] = pd[0];
    pd[0] = {gp_pad_i, ext[67:0]};
    ein1 = {cfg[0] ? 42'h0 : q[67:26], cfg[1] ? 7'h00 : q[9:3], cfg[1] ? q[9:3] : 7'h00,
      !rg[0][8] & q[76], cfg[0] ? q[83:77] : 7'h00};
    if (!cfg[0] && !cfg[2])
      ein1[53:38] = 16'h0000;
    ein2 = {cfg[0] ? q[67:26] : 42'h0, cfg[0] ? 3'h0 : q[2:0], cfg[0] ? q[2:0] : 3'h0,
      cfg[1] ? q[25:18] : 8'h00, cfg[0] ? q[17:10] : 8'h00};
    eout = {eho, cfg[1] ? atm_sh_o : sp1_o, cfg[0] ? ee_o : sp2_o, 2'h1, cfg};
    eap = {atm_pin_o & {8{cfg[1]}}, pci_pin_o & {8{cfg[0]}}};
  end
  always @(negedge hclk)
  begin
    if (vld && hresetn)
    begin
      ck(hp_pad_oe, ehoe);
      ck({s1_pad_oe, s2_pad_oe, atm_pad_oe, pci_pad_oe}, eoe);
      ck(gp_pad_oe, egoe);
      ck({hp_pad_o & ehoe, gp_pad_o & egoe}, {eho & ehoe, ego & egoe});
      ck({host_i, sp1_i, atm_sh_i, serial2_external_clock_in, pci_gp_i}, ein1);
      ck({pci_hp_i, sp2_i, ee_i, atm_pin_i, pci_pin_i}, ein2);
      ck({hp_pad_o, s1_pad_o, s2_pad_o, hresp, strap_status}, eout);
      ck({atm_pad_o, pci_pad_o}, eap);
    end
  end
  initial
  begin
    for (int k = 0; k < 8; k++)
    begin
      {cfg, flip, hresetn} <= {k[2:0], 2'b00};
      rg <= '{default: 16'h0000};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (30) @(posedge hclk);
      flip <= 1'b1;
      bus(1'b0, 8'h10, {28'h0000000, 1'b1, k[2:0]});
      for (int r = 0; r < 3; r++) bus(1'b1, 8'(4 * r), nx());
      for (int r = 0; r < 3; r++) bus(1'b0, 8'(4 * r), {16'h0000, rg[r]});
      bus(1'b1, 8'h10, 32'hFFFFFFFF);
      bus(1'b0, 8'h10, {28'h0000000, 1'b1, k[2:0]});
      bus(1'b0, 8'h40, 32'h00000000);
      repeat (20) @(posedge hclk);
      bus(1'b1, 8'h00, nx());
      repeat (20) @(posedge hclk);
      $display("strap config %0d done", k);
    end
    tally_and_finish();
  end
endmodule

/* spfm_pad_model.sv */
module spfm_pad_model (
  input wire logic [2:0] cfg,
  input wire logic flip,
  input wire logic [95:0] ext,
  input wire logic [15:0] gp_pad_o,
  input wire logic [15:0] gp_pad_oe,
  output logic [15:0] gp_pad_i,
  output logic pci_select_strap,
  output logic atm_port_select_strap,
  output logic host_width_strap_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Board resistors set straps; after latch they wander to prove they are ignored
  assign {host_width_strap_pin, atm_port_select_strap, pci_select_strap} =
    flip ? ext[2:0] : cfg;
  // Released pads never hold their last level
  assign gp_pad_i = gp_pad_oe & gp_pad_o | ~gp_pad_oe & ext[95:80];
endmodule

/* spfm_params.svh */
`ifndef SPFM_PARAMS_SVH
`define SPFM_PARAMS_SVH

// Pin group widths
`define SPFM_GP_W 16
`define SPFM_PGP_W 7
`define SPFM_S1_W 7
`define SPFM_S2_W 3
`define SPFM_HP_W 42
`define SPFM_HD_W 32
`define SPFM_HD_NARROW 16
`define SPFM_ATM_W 8
`define SPFM_PCI_W 8
`define SPFM_STRAP_W 3
`define SPFM_SYNC_W 87

// Positions on the general purpose bank
`define SPFM_GP_QCLK 1
`define SPFM_GP_SCLK 2
`define SPFM_GP_S2CLK 8
`define SPFM_GP_PCI_LO 9
`define SPFM_GP_PCI_HI 15

// Strap status fields
`define SPFM_ST_PCI 0
`define SPFM_ST_ATM 1
`define SPFM_ST_WIDE 2
`define SPFM_ST_DONE 3

// Register byte addresses
`define SPFM_OFF_EN 8'h00
`define SPFM_OFF_DIR 8'h04
`define SPFM_OFF_OUT 8'h08
`define SPFM_OFF_IN 8'h0C
`define SPFM_OFF_STRAP 8'h10

// Reset values
`define SPFM_EN_RST 16'h0000
`define SPFM_DIR_RST 16'h0000
`define SPFM_OUT_RST 16'h0000

// Cycles between reset release and strap latch (synchroniser depth)
`define SPFM_STRAP_WAIT 2'h2

`endif

/* spfm_pkg.sv */
`include "spfm_params.svh"

package spfm_pkg;

  typedef enum logic [0:0] {
    SPFM_CAP_WAIT = 1'b0,
    SPFM_CAP_DONE = 1'b1
  } spfm_cap_t;

  typedef struct packed {
    logic [`SPFM_GP_W-1:0] gpio_en;
    logic [`SPFM_GP_W-1:0] gpio_dir;
    logic [`SPFM_GP_W-1:0] gpio_out;
    logic [`SPFM_GP_W-1:0] gpio_in;
    logic pci_sel;
    logic atm_sel;
    logic host_wide;
    spfm_cap_t cap;
    logic [1:0] cap_cnt;
    logic ph_we;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [`SPFM_GP_W-1:0] gp_o;
    logic [`SPFM_GP_W-1:0] gp_oe;
    logic s2_clk;
    logic [`SPFM_PGP_W-1:0] pci_gp_i;
    logic [`SPFM_S1_W-1:0] s1_o;
    logic [`SPFM_S1_W-1:0] s1_oe;
    logic [`SPFM_S1_W-1:0] sp1_i;
    logic [`SPFM_S1_W-1:0] atm_sh_i;
    logic [`SPFM_S2_W-1:0] s2_o;
    logic [`SPFM_S2_W-1:0] s2_oe;
    logic [`SPFM_S2_W-1:0] sp2_i;
    logic [`SPFM_S2_W-1:0] ee_i;
    logic [`SPFM_HP_W-1:0] hp_o;
    logic [`SPFM_HP_W-1:0] hp_oe;
    logic [`SPFM_HP_W-1:0] host_i;
    logic [`SPFM_HP_W-1:0] pci_hp_i;
    logic [`SPFM_ATM_W-1:0] atm_o;
    logic [`SPFM_ATM_W-1:0] atm_oe;
    logic [`SPFM_ATM_W-1:0] atm_i;
    logic [`SPFM_PCI_W-1:0] pci_o;
    logic [`SPFM_PCI_W-1:0] pci_oe;
    logic [`SPFM_PCI_W-1:0] pci_i;
  } spfm_state_t;

endpackage

/* spfm_sync.sv */
module spfm_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  spfm_sync_if.snk port
);
  logic [W-1:0] meta;
  logic [W-1:0] held;

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta <= '0;
      held <= '0;
    end
    else
    begin
      meta <= port.raw;
      held <= meta;
    end
  end

  assign port.sync = held;
endmodule

/* spfm_sync_if.sv */
interface spfm_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport snk (input raw, output sync);
endinterface
